/* File: core/psb_map.svh */
// Register map, field positions, reset values and timing counts.
// Assumes a 10 MHz system clock; included by bare name.
`ifndef PSB_MAP_SVH
`define PSB_MAP_SVH

// ----------------------------------------------------------------
// Wishbone byte addresses
// ----------------------------------------------------------------
`define PSB_ADR_CTRL    8'h00
`define PSB_ADR_PERIOD  8'h04
`define PSB_ADR_PHASE   8'h08
`define PSB_ADR_DEAD1   8'h0C
`define PSB_ADR_DEAD2   8'h10
`define PSB_ADR_STATUS  8'h14
`define PSB_ADR_MASK    8'h18
`define PSB_ADR_STATE   8'h1C

// ----------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------
`define PSB_CTRL_DEFEAT1 0
`define PSB_CTRL_DEFEAT2 1
`define PSB_CTRL_ADAPT   2
`define PSB_CTRL_PEAK    3
`define PSB_CTRL_EXTSYNC 4

// ----------------------------------------------------------------
// Status bits
// ----------------------------------------------------------------
`define PSB_ST_OC      0
`define PSB_ST_PEAK    1
`define PSB_ST_NOLOAD  2
`define PSB_ST_DISABLE 3
`define PSB_ST_SSDONE  4

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define PSB_CTRL_RST  8'h00
`define PSB_MASK_RST  8'h00
`define PSB_PHASE_RST 8'h00
`define PSB_CLK_NS    100
`define PSB_OSC_NS    2000
`define PSB_OSC_CYC   ((`PSB_OSC_NS) / (`PSB_CLK_NS))
`define PSB_DEAD_NS   525
`define PSB_DEAD_CYC  (((`PSB_DEAD_NS) + (`PSB_CLK_NS) - 1) / (`PSB_CLK_NS))
`define PSB_SYNC_NS   85
`define PSB_SYNC_CYC  (((`PSB_SYNC_NS) + (`PSB_CLK_NS) - 1) / (`PSB_CLK_NS))

`endif

/* File: core/psb_pkg.sv */
// Types shared by the bridge output logic.
// Assumes nothing of its surroundings.
package psb_pkg;

  // ----------------------------------------------------------------
  // Restart sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_RUN   = 3'b001,
    ST_STOP  = 3'b010,
    ST_START = 3'b100
  } psb_state_t;

endpackage : psb_pkg

/* File: core/psb_sync2.sv */
// Two-flop synchroniser for asynchronous pin inputs.
// Assumes inputs are levels that stay stable for several clocks.
`timescale 1ns/1ns
module psb_sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         nrst,
  // Data
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] stage1_r;
  logic [W-1:0] stage2_r;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      stage1_r <= '0;
      stage2_r <= '0;
    end else begin
      stage1_r <= din;
      stage2_r <= stage1_r;
    end
  end

  assign dout = stage2_r;

endmodule : psb_sync2

/* File: core/psb_dead_time.sv */
// One half-bridge: complementary drive pair with programmable dead time.
// Assumes phaseIn, deadCycles, defeat and kill come from the same clock.
`timescale 1ns/1ns
module psb_dead_time (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       nrst,
  // Control
  input  wire logic       phaseIn,
  input  wire logic [7:0] deadCycles,
  input  wire logic       defeat,
  input  wire logic       kill,
  // Drives
  output logic            driveFirst,
  output logic            driveSecond
);

  logic       last_r, last_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic       first_r, first_nxt;
  logic       second_r, second_nxt;

  // ----------------------------------------------------------------
  // Dead time sequencing
  // ----------------------------------------------------------------
  always_comb begin
    last_nxt = phaseIn;
    cnt_nxt  = (cnt_r != 8'h00) ? cnt_r - 8'h01 : 8'h00;
    if (kill || (phaseIn != last_r)) begin
      cnt_nxt = defeat ? 8'h00 : deadCycles;
    end
    first_nxt  = !kill && (cnt_nxt == 8'h00) && phaseIn;
    second_nxt = !kill && (cnt_nxt == 8'h00) && !phaseIn;
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      last_r   <= 1'b0;
      cnt_r    <= 8'h00;
      first_r  <= 1'b0;
      second_r <= 1'b0;
    end else begin
      last_r   <= last_nxt;
      cnt_r    <= cnt_nxt;
      first_r  <= first_nxt;
      second_r <= second_nxt;
    end
  end

  assign driveFirst  = first_r;
  assign driveSecond = second_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  chk_no_overlap: assert property (!(first_r && second_r))
    else $error("both drives of a leg are high");
  chk_dead_gap: assert property (
    (!defeat && !kill && phaseIn != last_r && deadCycles != 8'h00)
      |=> !first_r && !second_r)
    else $error("no dead time after a phase change");
  chk_defeat_swap: assert property (
    (defeat && !kill && phaseIn != last_r)
      |=> (first_r == $past(phaseIn)) && (second_r != $past(phaseIn)))
    else $error("defeated leg did not swap at once");
  chk_kill_low: assert property (kill |=> !first_r && !second_r)
    else $error("drive stayed high while killed");

endmodule : psb_dead_time

/* File: core/psb_output_logic.sv */
// Output sequencing of a phase-shift full-bridge controller.
// Assumes comparator outputs arrive as asynchronous digital pins and
// nrst is released once the supply is above its lockout level.
//
// Contract
// - Leg 1 outputs complementary, each toggles per oscillator cycle, half rate.
// - Leg 2 pair likewise, phase shifted against the leg 1 pair.
// - Leg 2 duty may depart from half while the phase changes.
// - Dead time within each leg, separately programmed per leg.
// - Delay defeat per leg removes that leg's dead time.
// - Full adaptive delay: zero-current dead time is four times peak-current.
// - No-load turns outputs off below low level, on above high level.
// - Peak current mode ends the conduction interval of that cycle.
// - Overcurrent disables outputs, then soft stop and full soft start.
// - Sync pulse width caps the reachable phase shift.
// - Forced soft-start low or overcurrent disables all outputs.
// - External sync clocks the block; otherwise sync pin drives clock out.
// - After overcurrent, discharge soft start until low, then soft start.
`timescale 1ns/1ns
`include "psb_map.svh"
module psb_output_logic (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        nrst,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Comparator pins
  input  wire logic        overCurrentHit,
  input  wire logic        peakCurrentHit,
  input  wire logic        softstartDisableLow,
  input  wire logic        errorBelowTurnOff,
  input  wire logic        errorAboveTurnOn,
  input  wire logic [1:0]  currentLevel,
  input  wire logic [1:0]  adaptiveDelaySelect,
  // Sync pin
  input  wire logic        syncIn,
  output logic             syncOut,
  output logic             syncOe,
  // Bridge drives and soft start
  output logic             leg1DriveFirst,
  output logic             leg1DriveSecond,
  output logic             leg2DriveFirst,
  output logic             leg2DriveSecond,
  output logic             softstartDischarge,
  output logic             irq
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [9:0] pinS;
  logic       syncS, ocS, peakS, disS, errLowS, errHighS;
  logic [1:0] curS, adsS;

  psb_sync2 #(.W(10)) u_sync (
    .clock (clock),
    .nrst  (nrst),
    .din   ({syncIn, overCurrentHit, peakCurrentHit, softstartDisableLow,
             errorBelowTurnOff, errorAboveTurnOn, currentLevel,
             adaptiveDelaySelect}),
    .dout  (pinS)
  );
  assign {syncS, ocS, peakS, disS, errLowS, errHighS, curS, adsS} = pinS;

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [7:0]  ctrl_r, ctrl_nxt, period_r, period_nxt, phase_r, phase_nxt;
  logic [7:0]  dead1_r, dead1_nxt, dead2_r, dead2_nxt;
  logic [7:0]  status_r, status_nxt, mask_r, mask_nxt, stateRd;
  logic [31:0] rdat_r, rdat_nxt;
  logic        ack_r, ack_nxt, irq_r, irq_nxt, wbHit, wbWr;
  logic [4:0]  events;

  assign wbHit = wb_cyc_i && wb_stb_i && !ack_r;
  // A write lands at the edge at which the master sees ack high.
  assign wbWr  = wb_cyc_i && wb_stb_i && ack_r && wb_we_i && wb_sel_i[0];

  always_comb begin
    ctrl_nxt   = ctrl_r;
    period_nxt = period_r;
    phase_nxt  = phase_r;
    dead1_nxt  = dead1_r;
    dead2_nxt  = dead2_r;
    mask_nxt   = mask_r;
    status_nxt = status_r;
    rdat_nxt   = rdat_r;
    ack_nxt    = wbHit;
    if (wbWr) begin
      case (wb_adr_i)
        `PSB_ADR_CTRL:   ctrl_nxt   = wb_dat_i[7:0];
        `PSB_ADR_PERIOD: period_nxt = wb_dat_i[7:0];
        `PSB_ADR_PHASE:  phase_nxt  = wb_dat_i[7:0];
        `PSB_ADR_DEAD1:  dead1_nxt  = wb_dat_i[7:0];
        `PSB_ADR_DEAD2:  dead2_nxt  = wb_dat_i[7:0];
        `PSB_ADR_STATUS: status_nxt = status_r & ~wb_dat_i[7:0];
        `PSB_ADR_MASK:   mask_nxt   = wb_dat_i[7:0];
        default: ;
      endcase
    end
    // A new event wins over a clear in the same cycle.
    status_nxt = status_nxt | {3'b000, events};
    if (wbHit) begin
      case (wb_adr_i)
        `PSB_ADR_CTRL:   rdat_nxt = {24'h000000, ctrl_r};
        `PSB_ADR_PERIOD: rdat_nxt = {24'h000000, period_r};
        `PSB_ADR_PHASE:  rdat_nxt = {24'h000000, phase_r};
        `PSB_ADR_DEAD1:  rdat_nxt = {24'h000000, dead1_r};
        `PSB_ADR_DEAD2:  rdat_nxt = {24'h000000, dead2_r};
        `PSB_ADR_STATUS: rdat_nxt = {24'h000000, status_r};
        `PSB_ADR_MASK:   rdat_nxt = {24'h000000, mask_r};
        `PSB_ADR_STATE:  rdat_nxt = {24'h000000, stateRd};
        default:         rdat_nxt = 32'h00000000;
      endcase
    end
    irq_nxt = |(status_r & mask_r);
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ctrl_r   <= `PSB_CTRL_RST;
      period_r <= 8'(`PSB_OSC_CYC);
      phase_r  <= `PSB_PHASE_RST;
      dead1_r  <= 8'(`PSB_DEAD_CYC);
      dead2_r  <= 8'(`PSB_DEAD_CYC);
      mask_r   <= `PSB_MASK_RST;
      status_r <= 8'h00;
      rdat_r   <= 32'h00000000;
      ack_r    <= 1'b0;
      irq_r    <= 1'b0;
    end else begin
      ctrl_r   <= ctrl_nxt;
      period_r <= period_nxt;
      phase_r  <= phase_nxt;
      dead1_r  <= dead1_nxt;
      dead2_r  <= dead2_nxt;
      mask_r   <= mask_nxt;
      status_r <= status_nxt;
      rdat_r   <= rdat_nxt;
      ack_r    <= ack_nxt;
      irq_r    <= irq_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Oscillator, sync pin and phase timing
  // ----------------------------------------------------------------
  logic       ext, peakMode, tick, syncLvl, leg2Due;
  logic [7:0] oscCnt_r, oscCnt_nxt, hold_r, hold_nxt;
  logic [7:0] wCnt_r, wCnt_nxt, width_r, width_nxt;
  logic [7:0] perCnt_r, perCnt_nxt, perMeas_r, perMeas_nxt;
  logic [7:0] pCnt_r, pCnt_nxt, perEff, phaseMax, phaseEff;
  logic [7:0] softLimit_r;
  logic       syncPrev_r, syncOut_r, syncOut_nxt, syncOe_r, syncOe_nxt;
  logic       leg1Ph_r, leg1Ph_nxt, leg2Ph_r, leg2Ph_nxt, done_r, done_nxt;
  logic       stopState;

  assign ext      = ctrl_r[`PSB_CTRL_EXTSYNC];
  assign peakMode = ctrl_r[`PSB_CTRL_PEAK];
  assign syncLvl  = ext ? syncS : syncOut_r;

  always_comb begin
    // External sync edges replace the internal oscillator.
    tick = ext ? (syncS && !syncPrev_r)
               : (oscCnt_r == period_r - 8'h01);
    oscCnt_nxt  = (ext || tick) ? 8'h00 : oscCnt_r + 8'h01;
    hold_nxt    = (hold_r != 8'h00) ? hold_r - 8'h01 : 8'h00;
    if (!ext && tick) begin
      hold_nxt = 8'(`PSB_SYNC_CYC);
    end
    syncOut_nxt = (hold_nxt != 8'h00);
    syncOe_nxt  = !ext;
    // The sync pulse width is measured and taken off the phase ceiling.
    wCnt_nxt  = syncLvl ? ((wCnt_r == 8'hFF) ? wCnt_r : wCnt_r + 8'h01)
                        : 8'h00;
    width_nxt = (!syncLvl && wCnt_r != 8'h00) ? wCnt_r : width_r;
    perCnt_nxt  = tick ? 8'h00
                : ((perCnt_r == 8'hFF) ? perCnt_r : perCnt_r + 8'h01);
    perMeas_nxt = tick ? perCnt_r + 8'h01 : perMeas_r;
    perEff   = ext ? perMeas_r : period_r;
    phaseMax = (perEff > width_r) ? perEff - width_r : 8'h00;
    phaseEff = (phase_r < phaseMax) ? phase_r : phaseMax;
    if (softLimit_r < phaseEff) begin
      phaseEff = softLimit_r;
    end
    pCnt_nxt = tick ? 8'h00
             : ((pCnt_r == 8'hFF) ? pCnt_r : pCnt_r + 8'h01);
    // Leg 2 flips once per cycle, at the phase count or the peak trip.
    leg2Due = (tick || !done_r)
              && ((pCnt_nxt == phaseEff) || (peakMode && peakS));
    leg1Ph_nxt = leg1Ph_r ^ tick;
    leg2Ph_nxt = leg2Ph_r ^ leg2Due;
    done_nxt   = tick ? leg2Due : (done_r || leg2Due);
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      oscCnt_r   <= 8'h00;
      hold_r     <= 8'h00;
      syncPrev_r <= 1'b0;
      syncOut_r  <= 1'b0;
      syncOe_r   <= 1'b0;
      wCnt_r     <= 8'h00;
      width_r    <= 8'h00;
      perCnt_r   <= 8'h00;
      perMeas_r  <= 8'h00;
      pCnt_r     <= 8'h00;
      leg1Ph_r   <= 1'b0;
      leg2Ph_r   <= 1'b0;
      done_r     <= 1'b0;
    end else begin
      oscCnt_r   <= oscCnt_nxt;
      hold_r     <= hold_nxt;
      syncPrev_r <= syncS;
      syncOut_r  <= syncOut_nxt;
      syncOe_r   <= syncOe_nxt;
      wCnt_r     <= wCnt_nxt;
      width_r    <= width_nxt;
      perCnt_r   <= perCnt_nxt;
      perMeas_r  <= perMeas_nxt;
      pCnt_r     <= pCnt_nxt;
      leg1Ph_r   <= leg1Ph_nxt;
      leg2Ph_r   <= leg2Ph_nxt;
      done_r     <= done_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Fault, disable and soft start sequencing
  // ----------------------------------------------------------------
  psb_pkg::psb_state_t state_r, state_nxt;
  logic [7:0] softLimit_nxt;
  logic       noLoad_r, noLoad_nxt, disPrev_r, kill, ssDone;

  assign stopState = (state_r == psb_pkg::ST_STOP);

  always_comb begin
    state_nxt     = state_r;
    softLimit_nxt = softLimit_r;
    ssDone        = 1'b0;
    noLoad_nxt    = errLowS ? 1'b1 : (errHighS ? 1'b0 : noLoad_r);
    unique case (state_r)
      psb_pkg::ST_RUN: begin
        softLimit_nxt = 8'hFF;
        if (ocS) begin
          state_nxt = psb_pkg::ST_STOP;
        end else if (disS) begin
          state_nxt     = psb_pkg::ST_START;
          softLimit_nxt = 8'h00;
        end
      end
      psb_pkg::ST_STOP: begin
        softLimit_nxt = 8'h00;
        if (disS && !ocS) begin
          state_nxt = psb_pkg::ST_START;
        end
      end
      psb_pkg::ST_START: begin
        if (ocS) begin
          state_nxt     = psb_pkg::ST_STOP;
          softLimit_nxt = 8'h00;
        end else if (disS) begin
          softLimit_nxt = 8'h00;
        end else if (tick && softLimit_r >= perEff) begin
          state_nxt     = psb_pkg::ST_RUN;
          softLimit_nxt = 8'hFF;
          ssDone        = 1'b1;
        end else if (tick) begin
          softLimit_nxt = softLimit_r + 8'h01;
        end
      end
      default: begin
        state_nxt     = psb_pkg::ST_STOP;
        softLimit_nxt = 8'h00;
      end
    endcase
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_r     <= psb_pkg::ST_START;
      softLimit_r <= 8'h00;
      noLoad_r    <= 1'b1;
      disPrev_r   <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      softLimit_r <= softLimit_nxt;
      noLoad_r    <= noLoad_nxt;
      disPrev_r   <= disS;
    end
  end

  // All four drives go low on any shutdown cause.
  assign kill = stopState || disS || noLoad_r || ocS;

  assign events = {ssDone, disS && !disPrev_r, errLowS && !noLoad_r,
                   peakMode && peakS && leg2Due && (pCnt_nxt != phaseEff),
                   ocS && !stopState};
  assign stateRd = {2'b00, noLoad_r, leg2Ph_r, leg1Ph_r, state_r};

  // ----------------------------------------------------------------
  // Dead time and drive stages
  // ----------------------------------------------------------------
  function automatic logic [7:0] scaleDead(input logic [7:0] base,
                                           input logic [1:0] diff);
    logic [7:0] v;
    unique case (diff)
      2'd0: v = base;
      2'd1: v = base >> 1;
      2'd2: v = (base >> 2) + (base >> 4) + (base >> 6);
      2'd3: v = base >> 2;
    endcase
    if (v == 8'h00 && base != 8'h00) begin
      v = 8'h01;
    end
    return v;
  endfunction : scaleDead

  logic [1:0] diff;
  logic [7:0] deadEff1, deadEff2;

  // Dead time falls with load, four to one between zero and peak current.
  assign diff     = (curS > adsS) ? curS - adsS : 2'd0;
  assign deadEff1 = ctrl_r[`PSB_CTRL_ADAPT] ? scaleDead(dead1_r, diff)
                                            : dead1_r;
  assign deadEff2 = ctrl_r[`PSB_CTRL_ADAPT] ? scaleDead(dead2_r, diff)
                                            : dead2_r;

  psb_dead_time u_leg1 (
    .clock       (clock),
    .nrst        (nrst),
    .phaseIn     (leg1Ph_r),
    .deadCycles  (deadEff1),
    .defeat      (ctrl_r[`PSB_CTRL_DEFEAT1]),
    .kill        (kill),
    .driveFirst  (leg1DriveFirst),
    .driveSecond (leg1DriveSecond)
  );

  psb_dead_time u_leg2 (
    .clock       (clock),
    .nrst        (nrst),
    .phaseIn     (leg2Ph_r),
    .deadCycles  (deadEff2),
    .defeat      (ctrl_r[`PSB_CTRL_DEFEAT2]),
    .kill        (kill),
    .driveFirst  (leg2DriveFirst),
    .driveSecond (leg2DriveSecond)
  );

  assign wb_dat_o           = rdat_r;
  assign wb_ack_o           = ack_r;
  assign syncOut            = syncOut_r;
  assign syncOe             = syncOe_r;
  assign softstartDischarge = state_r[1];
  assign irq                = irq_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  sequence seqFault;
    ocS && !stopState;
  endsequence
  sequence seqDrained;
    stopState ##1 !stopState;
  endsequence

  chk_leg1_toggle: assert property (tick |=> leg1Ph_r != $past(leg1Ph_r))
    else $error("leg 1 phase did not flip on a tick");
  chk_leg2_once: assert property (
    (done_r && !tick) |=> $stable(leg2Ph_r))
    else $error("leg 2 flipped twice in one cycle");
  chk_phase_ceiling: assert property (phaseEff <= phaseMax)
    else $error("phase beyond sync-limited ceiling");
  chk_oc_restart: assert property (seqFault |=> stopState && !kill == 1'b0)
    else $error("overcurrent did not stop the outputs");
  chk_drain_release: assert property (
    seqDrained |-> $past(disS) && state_r == psb_pkg::ST_START)
    else $error("soft start began before discharge ended");
  chk_noload_hold: assert property (
    (noLoad_r && !errHighS)
      |=> noLoad_r ##1 (noLoad_r || $past(errHighS)))
    else $error("no-load released without high level");
  chk_peak_cut: assert property (
    (peakMode && peakS && !done_r && !tick) |=> leg2Ph_r != $past(leg2Ph_r))
    else $error("peak trip did not end conduction");
  chk_sync_dir: assert property (ext |=> !syncOe)
    else $error("sync pin driven while externally clocked");
  chk_adapt_ratio: assert property (
    (ctrl_r[`PSB_CTRL_ADAPT] && diff == 2'd3 && dead1_r[1:0] == 2'b00)
      |-> ({deadEff1, 2'b00} == {2'b00, dead1_r}) || dead1_r == 8'h00)
    else $error("adaptive dead time not a quarter at peak");

endmodule : psb_output_logic

/* File: tb/psb_gate_model.sv */
// Gate driver stand-in: counts shoot-through and times leg skew.
// Assumes the four drive commands of the bridge output logic.
`timescale 1ns/1ns
module psb_gate_model (
  // Drive commands
  input  wire logic l1f,
  input  wire logic l1s,
  input  wire logic l2f,
  input  wire logic l2s,
  // Observations
  output int        shootCount,
  output longint    skewNs
);
  time tFall;
  initial begin
    shootCount = 0;
    skewNs = 0;
    tFall = 0;
  end
  always @(posedge (l1f & l1s) or posedge (l2f & l2s)) begin
    shootCount++;
  end
  always @(negedge l1f) tFall = $time;
  always @(negedge l2f) skewNs = $time - tFall;
endmodule : psb_gate_model

/* File: tb/testbench.sv */
// Self-checking bench for the bridge output logic.
// Assumes the register map header and a 10 MHz clock.
`timescale 1ns/1ns
`include "psb_map.svh"
module testbench;
  logic clock, nrst, cyc, stb, we, oc, pk, ssl, bel, abv;
  logic [7:0] adr;
  logic [31:0] dat, rdData, q;
  logic [3:0] sel;
  logic [1:0] cur, adaptive_delay_select;
  logic ack, soe, d1a, d1b, d2a, d2b, dis, irq, syn, sout;
  int err_count, samples_checked, shootCount, g;
  longint skewNs;
  logic [7:0] adrs [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h18, 8'h20};
  logic [7:0] rsts [7] = '{8'h00, 8'h14, 8'h00, 8'h06, 8'h06, 8'h00, 8'h00};
  psb_output_logic i_psb_output_logic (.clock(clock), .nrst(nrst),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_dat_i(dat), .wb_sel_i(sel), .wb_dat_o(rdData), .wb_ack_o(ack),
    .overCurrentHit(oc), .peakCurrentHit(pk), .softstartDisableLow(ssl),
    .errorBelowTurnOff(bel), .errorAboveTurnOn(abv), .currentLevel(cur),
    .adaptiveDelaySelect(adaptive_delay_select), .syncIn(syn), .syncOut(sout), .syncOe(soe),
    .leg1DriveFirst(d1a), .leg1DriveSecond(d1b), .leg2DriveFirst(d2a),
    .leg2DriveSecond(d2b), .softstartDischarge(dis), .irq(irq));
  psb_gate_model i_psb_gate_model (.l1f(d1a), .l1s(d1b), .l2f(d2a),
    .l2s(d2b), .shootCount(shootCount), .skewNs(skewNs));
  initial begin
    clock = 0;
    forever #50 clock = ~clock;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t ns got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clock);
      n++;
    end while (ack !== 1'b1 && n < 50);
    chk(n < 50, 1'b1);
    q = rdData;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : xfer
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask : tick
  // Gap from the first drive falling to the second drive rising.
  task automatic gap(output int n);
    @(negedge d1a);
    @(negedge d1a);
    n = 0;
    #1;
    while (d1b !== 1'b1 && n < 40) begin
      @(posedge clock);
      #1;
      n++;
    end
  endtask : gap
  task automatic waitDone;
    int n;
    n = 0;
    do begin
      xfer(1'b0, `PSB_ADR_STATUS, 32'h0);
      n++;
    end while (q[4] !== 1'b1 && n < 400);
    chk(q[4], 1'b1);
    chk(irq, 1'b1);
    xfer(1'b1, `PSB_ADR_STATUS, 32'h1F);
    tick(2);
    chk(irq, 1'b0);
  endtask : waitDone
  task end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_of_test
  initial begin
    #3000000;
    err_count++;
    end_of_test();
  end
  initial begin
    {nrst, cyc, stb, we, oc, pk, ssl, bel, abv, syn} = '0;
    {adr, dat, cur, adaptive_delay_select, err_count, samples_checked} = '0;
    sel = 4'hF;
    tick(6);
    nrst <= 1'b1;
    foreach (adrs[i]) begin
      xfer(1'b0, adrs[i], 32'h0);
      chk(q, {24'h0, rsts[i]});
    end
    $display("register test done");
    abv <= 1'b1;
    xfer(1'b1, `PSB_ADR_MASK, 32'h10);
    waitDone();
    xfer(1'b1, `PSB_ADR_PHASE, 32'h0A);
    xfer(1'b1, `PSB_ADR_DEAD1, 32'h08);
    gap(g);
    chk(g, 8);
    xfer(1'b1, `PSB_ADR_CTRL, 32'h04);
    cur <= 2'h3;
    gap(g);
    chk(g, 2);
    tick(1);
    adaptive_delay_select <= 2'h3;
    gap(g);
    chk(g, 8);
    xfer(1'b1, `PSB_ADR_CTRL, 32'h01);
    gap(g);
    chk(g, 0);
    xfer(1'b1, `PSB_ADR_CTRL, 32'h00);
    gap(g);
    tick(60);
    chk(200 * skewNs / 4000, 50);
    chk(shootCount, 0);
    $display("drive test done");
    oc <= 1'b1;
    tick(5);
    #1;
    chk({d1a, d1b, d2a, d2b}, 4'h0);
    chk(dis, 1'b1);
    tick(1);
    oc <= 1'b0;
    tick(4);
    ssl <= 1'b1;
    tick(4);
    xfer(1'b0, `PSB_ADR_STATE, 32'h0);
    chk(q[2:0], 3'h4);
    chk(irq, 1'b0);
    ssl <= 1'b0;
    waitDone();
    $display("fault test done");
    bel <= 1'b1;
    abv <= 1'b0;
    tick(5);
    #1;
    chk({d1a, d1b, d2a, d2b}, 4'h0);
    tick(1);
    bel <= 1'b0;
    tick(40);
    #1;
    chk({d1a, d1b, d2a, d2b}, 4'h0);
    tick(1);
    abv <= 1'b1;
    tick(40);
    g = 0;
    repeat (40) begin
      @(posedge clock);
      #1;
      g = g | d1a | d1b;
    end
    chk(g, 1);
    xfer(1'b1, `PSB_ADR_CTRL, 32'h08);
    pk <= 1'b1;
    tick(24);
    pk <= 1'b0;
    xfer(1'b0, `PSB_ADR_STATUS, 32'h0);
    chk(q[1], 1'b1);
    chk(soe, 1'b1);
    @(posedge sout);
    tick(2);
    chk(sout, 1'b0);
    xfer(1'b1, `PSB_ADR_CTRL, 32'h10);
    tick(3);
    chk(soe, 1'b0);
    xfer(1'b0, `PSB_ADR_STATE, 32'h0);
    g = q[3];
    syn <= 1'b1;
    tick(2);
    syn <= 1'b0;
    tick(6);
    xfer(1'b0, `PSB_ADR_STATE, 32'h0);
    chk(q[3], !g[0]);
    $display("mode test done");
    end_of_test();
  end
endmodule : testbench
